/* File: bench/scad_addr_decode_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module scad_addr_decode_chk
(
   input wire logic                       clk_sys,
   input wire logic                       sys_rst,
   input wire scad_pkg::scad_reg_req_type reg_req,
   input wire logic [31:0]                reg_rdata_q,
   input wire logic                       mem_req_valid,
   input wire scad_pkg::scad_mem_req_type mem_req,
   input wire logic [3:0]                 chan_sel_q,
   input wire logic                       map_valid_q,
   input wire logic [19:5]                mem_addr_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_HOLD: assert property (!mem_req_valid |=> $stable({chan_sel_q, map_valid_q, mem_addr_q}))
      else $error("outputs moved without request");
   AST_PINS_ZERO: assert property (!map_valid_q |-> mem_addr_q == 15'h0000)
      else $error("pins driven without valid map");
   AST_NO_HIT: assert property (chan_sel_q == 4'h0 |-> !map_valid_q)
      else $error("valid map without hit");
   AST_AP: assert property (mem_req_valid && mem_req.col_phase ##1 map_valid_q
      |-> mem_addr_q[15] == $past(mem_req.auto_precharge))
      else $error("precharge pin wrong");
   AST_COL_LOW: assert property (mem_req_valid && mem_req.col_phase ##1 map_valid_q
      |-> mem_addr_q[12:5] == $past(mem_req.paddr[10:3]))
      else $error("column pins wrong");
   AST_ROW: assert property (mem_req_valid && !mem_req.col_phase ##1 map_valid_q
      |-> mem_addr_q[15:5] == $past(mem_req.paddr[21:11]))
      else $error("row pins wrong");
   AST_BANK: assert property (mem_req_valid ##1 map_valid_q |-> mem_addr_q[19] inside
      {$past(mem_req.paddr[22]), $past(mem_req.paddr[23]), $past(mem_req.paddr[25])})
      else $error("bank pin wrong");
   AST_RDATA: assert property (!reg_req.read |=> reg_rdata_q == 32'h0000_0000)
      else $error("read data outside its cycle");
endmodule
bind scad_addr_decode scad_addr_decode_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .mem_req_valid(mem_req_valid),
   .mem_req(mem_req), .chan_sel_q(chan_sel_q), .map_valid_q(map_valid_q),
   .mem_addr_q(mem_addr_q));
`default_nettype wire

/* File: bench/scad_sdram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side memory: latches the bank select pins 18 and 19 each cycle
module scad_sdram_model
(
   input  wire logic        clk_sys,
   input  wire logic [19:5] mem_addr_q,
   output logic [1:0]       bank_seen_q
);
   // bank select as the device takes it: high bit on pin 18, low bit on pin 19
   always_ff @(posedge clk_sys)
      bank_seen_q <= {mem_addr_q[18], mem_addr_q[19]};
endmodule
`default_nettype wire

/* File: bench/test_sdram_channel_addr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sdram_channel_addr_decode;
   logic                       clk_sys;
   logic                       sys_rst;
   scad_pkg::scad_reg_req_type reg_req;
   scad_pkg::scad_mem_req_type mem_req;
   logic                       mem_req_valid;
   logic [31:0]                reg_rdata_q;
   logic [3:0]                 chan_sel_q, exp_sel;
   logic                       map_valid_q, exp_val, live;
   logic [19:5]                mem_addr_q, exp_pins;
   logic [18:0]                ctl [4];
   logic [14:0]                msk [4];
   int                         n_mismatch, samples_checked, seed, hit, k;
   logic [1:0]                 bank_seen, prev_bank;
   logic [31:0]                r;
   scad_addr_decode i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
      .chan_sel_q(chan_sel_q), .map_valid_q(map_valid_q), .mem_addr_q(mem_addr_q));
   scad_sdram_model i_far (.clk_sys(clk_sys), .mem_addr_q(mem_addr_q),
      .bank_seen_q(bank_seen));
   task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_req.write <= 1'b1;
      reg_req.addr <= a;
      reg_req.wdata <= d;
      @(posedge clk_sys);
      reg_req.write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_req.read <= 1'b1;
      reg_req.addr <= a;
      @(posedge clk_sys);
      reg_req.read <= 1'b0;
      #1 chk("rdata", e, reg_rdata_q);
   endtask
   function automatic logic [19:5] pins_of(input logic [1:0] g, input logic [35:0] p,
      input logic c, input logic ap);
      logic [19:5] r;
      r[15:5] = p[21:11];
      if (c)
      begin
         r[12:5] = p[10:3];
         r[15] = ap;
         r[14:13] = g == 2'h0 ? {ap, ap} : g == 2'h1 ? p[23:22] : p[24:23];
      end
      r[19:16] = g == 2'h0 ? {p[22], p[23], p[21], p[20]} : g == 2'h1 ? {4{p[23]}}
         : {p[25], p[26], p[25], p[22]};
      return r;
   endfunction
   always @(posedge clk_sys)
      if (sys_rst)
         {exp_sel, exp_val, exp_pins} = '0;
      else if (mem_req_valid)
      begin
         exp_sel = 4'h0;
         hit = -1;
         for (int n = 3; n >= 0; n--)
            if (ctl[n][18] && ((mem_req.paddr[35:21] ^ ctl[n][14:0]) & ~msk[n]) == 15'h0)
            begin
               exp_sel[n] = 1'b1;
               hit = n;
            end
         exp_val = hit >= 0 && ctl[hit][15] && ctl[hit][17:16] != 2'h3;
         exp_pins = exp_val ? pins_of(ctl[hit][17:16], mem_req.paddr, mem_req.col_phase,
            mem_req.auto_precharge) : 15'h0;
      end
   always @(negedge clk_sys)
      if (live)
      begin
         chk("chan_sel_q", exp_sel, chan_sel_q);
         chk("map_valid_q", exp_val, map_valid_q);
         chk("mem_addr_q", exp_pins, mem_addr_q);
         chk("bank_seen_q", prev_bank, bank_seen);
         prev_bank = {exp_pins[18], exp_pins[19]};
      end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (6000) @(posedge clk_sys);
      n_mismatch++;
      report_and_stop();
   end
   initial
   begin
      {sys_rst, reg_req, mem_req, mem_req_valid, live, seed} = {1'b1, 42'h0, 38'h0, 2'h0, 32'd99};
      prev_bank = 2'h0;
      for (int n = 0; n < 4; n++)
         {ctl[n], msk[n]} = {19'h08000, 15'h0};
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      live = 1'b1;
      for (int n = 0; n < 4; n++)
         rd(8'h08 * n, 32'h0000_8000);
      rd(8'h44, 32'h0);
      $display("test reset done");
      for (int p = 0; p < 2; p++)
      begin
         {ctl[0], msk[0], ctl[1], msk[1]} = {19'h48000, 15'h1, 1'b1 ^ p[0], 18'h18002, 15'h0};
         {ctl[2], msk[2]} = {19'h68004, 15'h7ff3};
         ctl[3] = p ? 19'h78008 : 19'h40008;
         msk[3] = 15'h1;
         for (int n = 0; n < 4; n++)
         begin
            wr(8'h08 * n, {13'h0, ctl[n]});
            wr(8'h08 * n + 8'h04, {17'h0, msk[n]});
            rd(8'h08 * n, {13'h0, ctl[n]});
            rd(8'h08 * n + 8'h04, {17'h0, msk[n]});
         end
         wr(8'h30, 32'hffff_ffff);
         rd(8'h30, 32'h0);
         repeat (400)
         begin
            @(posedge clk_sys);
            r = $random(seed);
            k = r[1:0];
            mem_req_valid <= r[3:2] != 2'h0;
            mem_req.paddr <= {r[4] ? r[31:17] : ctl[k][14:0] ^ (r[31:17] & msk[k]),
               21'($random(seed))};
            mem_req.col_phase <= $random(seed) % 2 != 0;
            mem_req.auto_precharge <= $random(seed) % 2 != 0;
         end
         @(posedge clk_sys);
         mem_req_valid <= 1'b0;
         rd(8'h40, {27'h0, exp_val, exp_sel});
         $display("test mapping pass %0d done", p);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: rtl/scad_addr_decode.sv */
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "scad_regs.svh"

// Operation
// - an enabled channel is hit when paddr[35:21] equals its base with the masked positions cleared on both.
// - each of the four channels keeps its own base and mask over address bits 35 to 21.
// - with two banks the bank select leaves on memory address pin 19.
// - with four banks the bank select leaves on pins 19 (low) and 18 (high).
// - in the column phase the precharge pins follow the auto-precharge request.
// - row 11 column 8 maps pins 19..16 to bits 22,23,21,20 and row pins 15..13 to 21..19.
// - row 11 column 9 puts bit 23 on pins 19..16 and column pins 14,13 carry 23,22.
// - row 12 column 10 maps pins 19..16 to 25,26,25,22 and column pins 14,13 to 24,23.
// - column pins 12..5 carry bits 10..3 and row pins 15..5 carry bits 21..11.
// - a per-channel width field must be set for that channel to map; when clear, map_valid_q stays low and the pins stay zero.
module scad_addr_decode
(
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   input  wire scad_pkg::scad_reg_req_type  reg_req,
   output logic [31:0]                      reg_rdata_q,
   input  wire logic                        mem_req_valid,
   input  wire scad_pkg::scad_mem_req_type  mem_req,
   output logic [3:0]                       chan_sel_q,
   output logic                             map_valid_q,
   output logic [19:5]                      mem_addr_q
);

   scad_pkg::scad_chan_cfg_type cfg_q [4];
   scad_pkg::scad_chan_cfg_type cfg_sel;
   logic [3:0]                  hit;
   logic [1:0]                  sel_idx;
   logic                        found;
   logic [19:5]                 addr_d;
   logic                        map_ok;
   logic [1:0]                  reg_ch;
   logic                        reg_in_ch;
   logic [35:0]                 pa;
   logic                        ap;

   assign pa        = mem_req.paddr;
   assign ap        = mem_req.auto_precharge;
   assign reg_ch    = reg_req.addr[4:3];
   assign reg_in_ch = (reg_req.addr < `SCAD_CH_AREA_END) && (reg_req.addr[1:0] == 2'h0);

   // per-channel configuration registers
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (sys_rst)
         begin
            cfg_q[i].base               <= `SCAD_BASE_RST;
            cfg_q[i].channel_mask_field <= `SCAD_MASK_RST;
            cfg_q[i].bus_width_field    <= `SCAD_WIDE_RST;
            cfg_q[i].geom               <= scad_pkg::scad_geom_type'(`SCAD_GEOM_RST);
            cfg_q[i].enable             <= `SCAD_EN_RST;
         end
         else if (reg_req.write && reg_in_ch && reg_ch == i[1:0])
         begin
            if (reg_req.addr[2] == `SCAD_CH_MASK_OFF >> 2)
            begin
               cfg_q[i].channel_mask_field <=
                  reg_req.wdata[`SCAD_MASK_MSB:`SCAD_MASK_LSB];
            end
            else
            begin
               cfg_q[i].base            <= reg_req.wdata[`SCAD_BASE_MSB:`SCAD_BASE_LSB];
               cfg_q[i].bus_width_field <= reg_req.wdata[`SCAD_WIDE_BIT];
               cfg_q[i].geom            <= scad_pkg::scad_geom_type'(
                  reg_req.wdata[`SCAD_GEOM_MSB:`SCAD_GEOM_LSB]);
               cfg_q[i].enable          <= reg_req.wdata[`SCAD_EN_BIT];
            end
         end
      end
   end

   // register read data, one cycle after the read strobe
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         reg_rdata_q <= 32'h0000_0000;
      end
      else if (reg_req.read)
      begin
         reg_rdata_q <= 32'h0000_0000;
         if (reg_in_ch && reg_req.addr[2] == `SCAD_CH_MASK_OFF >> 2)
         begin
            reg_rdata_q[`SCAD_MASK_MSB:`SCAD_MASK_LSB] <= cfg_q[reg_ch].channel_mask_field;
         end
         else if (reg_in_ch)
         begin
            reg_rdata_q[`SCAD_BASE_MSB:`SCAD_BASE_LSB] <= cfg_q[reg_ch].base;
            reg_rdata_q[`SCAD_WIDE_BIT]                <= cfg_q[reg_ch].bus_width_field;
            reg_rdata_q[`SCAD_GEOM_MSB:`SCAD_GEOM_LSB] <= cfg_q[reg_ch].geom;
            reg_rdata_q[`SCAD_EN_BIT]                  <= cfg_q[reg_ch].enable;
         end
         else if (reg_req.addr == `SCAD_STATUS_OFF)
         begin
            reg_rdata_q[`SCAD_ST_SEL_MSB:`SCAD_ST_SEL_LSB] <= chan_sel_q;
            reg_rdata_q[`SCAD_ST_VALID_BIT]                <= map_valid_q;
         end
      end
      else
      begin
         reg_rdata_q <= 32'h0000_0000;
      end
   end

   // masked base compare per channel
   for (genvar g = 0; g < 4; g++)
   begin : g_hit
      assign hit[g] = cfg_q[g].enable &&
         ((pa[35:21] & ~cfg_q[g].channel_mask_field) ==
          (cfg_q[g].base & ~cfg_q[g].channel_mask_field));
   end

   // bank, row and column split for the hit channel
   always_comb
   begin
      sel_idx = 2'h0;
      found   = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         if (hit[i] && !found)
         begin
            sel_idx = i[1:0];
            found   = 1'b1;
         end
      end
      cfg_sel = cfg_q[sel_idx];
      addr_d  = 15'h0000;
      map_ok  = 1'b0;
      if (found && cfg_sel.bus_width_field)
      begin
         map_ok = 1'b1;
         if (mem_req.col_phase)
         begin
            addr_d[12:5] = pa[10:3];
         end
         else
         begin
            addr_d[15:5] = pa[21:11];
         end
         unique case (cfg_sel.geom)
            scad_pkg::SCAD_GEOM_R11_C8:
            begin
               addr_d[19:16] = {pa[22], pa[23], pa[21], pa[20]};
               if (mem_req.col_phase)
               begin
                  addr_d[15:13] = {3{ap}};
               end
            end
            scad_pkg::SCAD_GEOM_R11_C9:
            begin
               addr_d[19:16] = {4{pa[23]}};
               if (mem_req.col_phase)
               begin
                  addr_d[15:13] = {ap, pa[23], pa[22]};
               end
            end
            scad_pkg::SCAD_GEOM_R12_C10:
            begin
               addr_d[19:16] = {pa[25], pa[26], pa[25], pa[22]};
               if (mem_req.col_phase)
               begin
                  addr_d[15:13] = {ap, pa[24], pa[23]};
               end
            end
            default:
            begin
               addr_d = 15'h0000;
               map_ok = 1'b0;
            end
         endcase
      end
   end

   // registered pin and select outputs
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         chan_sel_q  <= 4'h0;
         map_valid_q <= 1'b0;
         mem_addr_q  <= 15'h0000;
      end
      else if (mem_req_valid)
      begin
         chan_sel_q  <= hit;
         map_valid_q <= map_ok;
         mem_addr_q  <= addr_d;
      end
   end

endmodule
`default_nettype wire

/* File: rtl/scad_pkg.sv */
package scad_pkg;

   typedef enum logic [1:0]
   {
      SCAD_GEOM_R11_C8  = 2'b00,
      SCAD_GEOM_R11_C9  = 2'b01,
      SCAD_GEOM_R12_C10 = 2'b10
   } scad_geom_type;

   typedef struct packed
   {
      logic          enable;
      scad_geom_type geom;
      logic          bus_width_field;
      logic [14:0]   channel_mask_field;
      logic [14:0]   base;
   } scad_chan_cfg_type;

   typedef struct packed
   {
      logic        write;
      logic        read;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } scad_reg_req_type;

   typedef struct packed
   {
      logic [35:0] paddr;
      logic        col_phase;
      logic        auto_precharge;
   } scad_mem_req_type;

endpackage

/* File: rtl/scad_regs.svh */
`ifndef SCAD_REGS_SVH
`define SCAD_REGS_SVH

// register offsets (byte addresses)
`define SCAD_CH_STRIDE     8'h08
`define SCAD_CH_CTRL_OFF   8'h00
`define SCAD_CH_MASK_OFF   8'h04
`define SCAD_STATUS_OFF    8'h40
`define SCAD_CH_AREA_END   8'h20

// channel_control_reg field positions
`define SCAD_BASE_LSB      0
`define SCAD_BASE_MSB      14
`define SCAD_WIDE_BIT      15
`define SCAD_GEOM_LSB      16
`define SCAD_GEOM_MSB      17
`define SCAD_EN_BIT        18

// channel_mask_field register field positions
`define SCAD_MASK_LSB      0
`define SCAD_MASK_MSB      14

// status register field positions
`define SCAD_ST_SEL_LSB    0
`define SCAD_ST_SEL_MSB    3
`define SCAD_ST_VALID_BIT  4

// reset values
`define SCAD_BASE_RST      15'h0000
`define SCAD_MASK_RST      15'h0000
`define SCAD_WIDE_RST      1'b1
`define SCAD_GEOM_RST      2'h0
`define SCAD_EN_RST        1'b0

`endif
